// File: pkg/tsa_pkg.sv
// Constants shared by the touch-scan clock, pen-up and aux configuration block.
// Assumes a byte-wide register port that the serial host interface already decodes.
// Functional notes
// - Apply gap delay in self-controlled scans; host mode only for X,Y or X,Y,Z1,Z2.
// - Gap is timed from end of one data set to start of the next.
// - Delay clock select bit: 0 internal oscillator, 1 master clock; resets to 1.
// - Seven-bit divider makes the 1 MHz delay clock; code 0 divides by 128; reset 1.
// - Master clock on the delay timer times gaps and pen-up debounce, never conversions.
// - Converter clock select bit: 0 internal oscillator, 1 master clock; resets to 1.
// - Second divider makes converter clock; software keeps pulse width above 40 ns.
// - Converter clock drives conversions and sequencer timers, never the gap delay.
// - Interface bit records host interface: 0 SPI, 1 I2C.
// - Host hold bit with host control enabled stops result buffer updates.
// - Debounce counter ticks at one eighth of the selected debounce duration.
// - Oscillator-timed durations scale with the oscillator's actual frequency.
// - Four bits enable first aux, second aux, battery and heat in auto scan.
// - Selection bit picks first or second thermal sense method for auto scan.
// - Separate bits set each aux input to voltage or resistance measurement.
// - Bias bit picks internal or external bias resistance for aux resistance.
// - Delay enable bit: 0 disables the gap delay between touch measurements, 1 enables.
package tsa_pkg;
  // ****************************************************************
  // Register offsets and reset values
  // ****************************************************************
  localparam logic [7:0] OFF_SCAN_TIMER   = 8'h0f;
  localparam logic [7:0] OFF_DELAY_CLK    = 8'h10;
  localparam logic [7:0] OFF_CONV_CLK     = 8'h11;
  localparam logic [7:0] OFF_IFACE_DEB    = 8'h12;
  localparam logic [7:0] OFF_AUX_SEL      = 8'h13;
  localparam logic [7:0] RST_SCAN_TIMER   = 8'h40;
  localparam logic [7:0] RST_DELAY_CLK    = 8'h81;
  localparam logic [7:0] RST_CONV_CLK     = 8'h81;
  localparam logic [7:0] RST_IFACE_DEB    = 8'h00;
  localparam logic [7:0] RST_AUX_SEL      = 8'h00;
  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int         BIT_DELAY_EN     = 7;
  localparam int         BIT_CLK_SEL      = 7;
  localparam int         DIV_MSB          = 6;
  localparam int         BIT_IFACE_I2C    = 7;
  localparam int         BIT_HOLD_MODE    = 6;
  localparam int         BIT_HOLD         = 5;
  localparam int         DEB_MSB          = 2;
  localparam int         BIT_FIRST_AUXILIARY_INPUT_EN      = 7;
  localparam int         BIT_SECOND_AUXILIARY_INPUT_EN      = 6;
  localparam int         BIT_VBAT_EN      = 5;
  localparam int         BIT_TEMP_EN      = 4;
  localparam int         BIT_TEMP_SEL     = 3;
  localparam int         BIT_FIRST_AUXILIARY_INPUT_RES     = 2;
  localparam int         BIT_SECOND_AUXILIARY_INPUT_RES     = 1;
  localparam int         BIT_EXT_BIAS     = 0;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int         CLK_PERIOD_NS    = 10;
  localparam int         CONV_PULSE_NS    = 40;
  localparam int         CONV_PULSE_CYC   = (CONV_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] DEB_WINDOW_TICKS = 4'h8;
  typedef enum logic [1:0] {
    TSA_IDLE = 2'b00,
    TSA_WAIT = 2'b01,
    TSA_FIRE = 2'b11
  } tsa_gap_t;
endpackage

// File: hw/tsa_mclk_div.sv
// Master clock divider producing a one-cycle enable pulse.
// Assumes the master clock is the only clock; code zero means divide by 128.
`timescale 1ns/1ps
module tsa_mclk_div #(
  parameter int W = 7
) (
  input  wire logic         ref_clk,  // master clock
  input  wire logic         reset_n,  // synchronous reset, active low
  input  wire logic [W-1:0] div_code, // divide code, 0 means 2**W
  output logic              tick_q    // one-cycle enable pulse
);
  logic [W-1:0] cnt_q;

  // Reloading code minus one wraps code zero to all ones, giving 2**W cycles.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else if (cnt_q == '0) begin
      cnt_q  <= div_code - W'(1);
      tick_q <= 1'b1;
    end else begin
      cnt_q  <= cnt_q - W'(1);
      tick_q <= 1'b0;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // A new code takes effect at the next reload, so a tick must come under code one first.
  a_div_by_one: assert property ((div_code == W'(1))[*2] ##0 tick_q |=> tick_q)
    else $error("divide by one does not tick every cycle");
  a_div_by_two: assert property ((div_code == W'(2))[*3] ##0 tick_q |=> !tick_q ##1 tick_q)
    else $error("divide by two does not alternate");
endmodule

// File: hw/tsa_penup_deb.sv
// Pen-up debounce: removal must hold for eight debounce ticks.
// Assumes base_tick is the nominal 1 MHz delay-timer enable.
`timescale 1ns/1ps
module tsa_penup_deb (
  input  wire logic       ref_clk,    // master clock
  input  wire logic       reset_n,    // synchronous reset, active low
  input  wire logic       base_tick,  // nominal 1 MHz enable
  input  wire logic [2:0] deb_code,   // debounce code
  input  wire logic       pen_absent, // raw pen-removed level
  output logic            pen_up_q    // debounced pen removal
);
  import tsa_pkg::*;

  logic [5:0] pre_q;
  logic [3:0] win_q;

  // Prescale limit gives a tick period of duration/8, i.e. 2**(code-1) base ticks.
  function automatic logic [5:0] pre_limit(input logic [2:0] code);
    pre_limit = 6'((7'h01 << (code - 3'h1)) - 7'h01);
  endfunction

  always_ff @(posedge ref_clk) begin
    if (!reset_n || !pen_absent) begin
      pre_q    <= '0;
      win_q    <= '0;
      pen_up_q <= 1'b0;
    end else if (deb_code == 3'h0) begin
      pen_up_q <= 1'b1;
    end else if (base_tick && !pen_up_q) begin
      if (pre_q == pre_limit(deb_code)) begin
        pre_q <= '0;
        win_q <= win_q + 4'h1;
        if (win_q + 4'h1 == DEB_WINDOW_TICKS) begin
          pen_up_q <= 1'b1;
        end
      end else begin
        pre_q <= pre_q + 6'h01;
      end
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_pen_touch_clear: assert property (!pen_absent |=> !pen_up_q)
    else $error("pen up stays set while pen is touching");
  a_zero_debounce: assert property (pen_absent && deb_code == 3'h0 |=> pen_up_q)
    else $error("code zero does not report removal at once");
endmodule

// File: hw/tsa_top.sv
// Clock selection, gap delay, buffer arbitration, pen-up debounce and auto-aux configuration.
// Assumes ref_clk is the external master clock and osc_tick marks internal oscillator periods.
`timescale 1ns/1ps
module tsa_top (
  input  wire logic        ref_clk,          // master clock, 100 MHz
  input  wire logic        reset_n,          // synchronous reset, active low
  input  wire logic [7:0]  reg_addr,         // register offset within the page
  input  wire logic        reg_wr,           // register write strobe
  input  wire logic [7:0]  reg_wdata,        // register write data
  output logic      [7:0]  reg_rdata,        // registered read data
  input  wire logic        osc_tick,         // internal oscillator enable pulse
  input  wire logic        host_ctrl_mode,   // 1 when the scan is host controlled
  input  wire logic        set_is_xy,        // current set is X,Y or X,Y,Z1,Z2
  input  wire logic        set_done,         // pulse at end of a conversion data set
  input  wire logic [15:0] delay_ticks,      // gap length in delay-timer ticks
  input  wire logic        pen_absent,       // raw pen-removed level
  input  wire logic        buf_host_reading, // host read of the buffer in progress
  output logic             conv_clk_en,      // converter and sequencer enable pulse
  output logic             delay_clk_en,     // delay-timer enable pulse
  output logic             delay_active,     // gap delay running
  output logic             scan_start,       // pulse: next data set may start
  output logic             buf_update_en,    // result buffer may be written
  output logic             iface_i2c,        // host interface is I2C
  output logic             pen_up,           // debounced pen removal
  output logic             auto_first_auxiliary_input_en,     // first auxiliary input in auto scan
  output logic             auto_second_auxiliary_input_en,     // second auxiliary input in auto scan
  output logic             auto_vbat_en,     // battery in auto scan
  output logic             auto_temp_en,     // die heat reading in auto scan
  output logic             temp_method_sel,  // 1 selects second thermal sense method
  output logic             first_auxiliary_input_resist,      // first aux measures resistance
  output logic             second_auxiliary_input_resist,      // second aux measures resistance
  output logic             ext_bias          // external bias resistance
);
  import tsa_pkg::*;

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] scan_tmr_q;
  logic [7:0] dly_clk_q;
  logic [7:0] conv_clk_q;
  logic [7:0] iface_q;
  logic [7:0] aux_sel_q;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      scan_tmr_q <= RST_SCAN_TIMER;
      dly_clk_q  <= RST_DELAY_CLK;
      conv_clk_q <= RST_CONV_CLK;
      iface_q    <= RST_IFACE_DEB;
      aux_sel_q  <= RST_AUX_SEL;
    end else if (reg_wr) begin
      case (reg_addr)
        OFF_SCAN_TIMER: scan_tmr_q <= reg_wdata;
        OFF_DELAY_CLK:  dly_clk_q  <= reg_wdata;
        OFF_CONV_CLK:   conv_clk_q <= reg_wdata;
        // Reserved bits are stored as written; software keeps them zero.
        OFF_IFACE_DEB:  iface_q    <= reg_wdata;
        OFF_AUX_SEL:    aux_sel_q  <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else begin
      case (reg_addr)
        OFF_SCAN_TIMER: reg_rdata <= scan_tmr_q;
        OFF_DELAY_CLK:  reg_rdata <= dly_clk_q;
        OFF_CONV_CLK:   reg_rdata <= conv_clk_q;
        OFF_IFACE_DEB:  reg_rdata <= iface_q;
        OFF_AUX_SEL:    reg_rdata <= aux_sel_q;
        default:        reg_rdata <= 8'h00;
      endcase
    end
  end

  // Configuration outputs are the register bits themselves.
  assign iface_i2c       = iface_q[BIT_IFACE_I2C];
  assign auto_first_auxiliary_input_en    = aux_sel_q[BIT_FIRST_AUXILIARY_INPUT_EN];
  assign auto_second_auxiliary_input_en    = aux_sel_q[BIT_SECOND_AUXILIARY_INPUT_EN];
  assign auto_vbat_en    = aux_sel_q[BIT_VBAT_EN];
  assign auto_temp_en    = aux_sel_q[BIT_TEMP_EN];
  assign temp_method_sel = aux_sel_q[BIT_TEMP_SEL];
  assign first_auxiliary_input_resist     = aux_sel_q[BIT_FIRST_AUXILIARY_INPUT_RES];
  assign second_auxiliary_input_resist     = aux_sel_q[BIT_SECOND_AUXILIARY_INPUT_RES];
  assign ext_bias        = aux_sel_q[BIT_EXT_BIAS];

  // ****************************************************************
  // Clock enables
  // ****************************************************************
  logic dly_div_tick;
  logic conv_div_tick;

  function automatic logic pick_tick(input logic use_mclk, input logic mclk_tick, input logic osc);
    pick_tick = use_mclk ? mclk_tick : osc;
  endfunction

  tsa_mclk_div #(.W(7)) u_dly_div (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .div_code (dly_clk_q[DIV_MSB:0]),
    .tick_q   (dly_div_tick)
  );

  // Software must pick a code whose pulse spans at least CONV_PULSE_CYC cycles.
  tsa_mclk_div #(.W(7)) u_conv_div (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .div_code (conv_clk_q[DIV_MSB:0]),
    .tick_q   (conv_div_tick)
  );

  // The two selections are kept apart so the gap timer never borrows the converter rate.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      delay_clk_en <= 1'b0;
      conv_clk_en  <= 1'b0;
    end else begin
      delay_clk_en <= pick_tick(dly_clk_q[BIT_CLK_SEL], dly_div_tick, osc_tick);
      conv_clk_en  <= pick_tick(conv_clk_q[BIT_CLK_SEL], conv_div_tick, osc_tick);
    end
  end

  // ****************************************************************
  // Gap delay between data sets
  // ****************************************************************
  tsa_gap_t    gap_q;
  logic [15:0] gap_cnt_q;
  logic        gap_apply;

  assign gap_apply = scan_tmr_q[BIT_DELAY_EN] && (!host_ctrl_mode || set_is_xy) && (delay_ticks != 16'h0000);

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      gap_q        <= TSA_IDLE;
      gap_cnt_q    <= '0;
      delay_active <= 1'b0;
      scan_start   <= 1'b0;
    end else begin
      scan_start <= 1'b0;
      case (gap_q)
        TSA_IDLE: begin
          if (set_done && gap_apply) begin
            gap_q        <= TSA_WAIT;
            gap_cnt_q    <= '0;
            delay_active <= 1'b1;
          end else if (set_done) begin
            scan_start <= 1'b1;
          end
        end
        TSA_WAIT: begin
          if (delay_clk_en) begin
            gap_cnt_q <= gap_cnt_q + 16'h0001;
            if (gap_cnt_q + 16'h0001 >= delay_ticks) begin
              gap_q        <= TSA_FIRE;
              delay_active <= 1'b0;
            end
          end
        end
        TSA_FIRE: begin
          scan_start <= 1'b1;
          gap_q      <= TSA_IDLE;
        end
        default: begin
          gap_q        <= TSA_IDLE;
          delay_active <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Buffer arbitration
  // ****************************************************************
  // Host hold only counts in host-controlled arbitration; otherwise a live read blocks writes.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      buf_update_en <= 1'b1;
    end else if (iface_q[BIT_HOLD_MODE]) begin
      buf_update_en <= !iface_q[BIT_HOLD];
    end else begin
      buf_update_en <= !buf_host_reading;
    end
  end

  // ****************************************************************
  // Pen-up debounce
  // ****************************************************************
  // Timing from the selected delay clock scales with the oscillator when it is chosen.
  tsa_penup_deb u_deb (
    .ref_clk    (ref_clk),
    .reset_n    (reset_n),
    .base_tick  (delay_clk_en),
    .deb_code   (iface_q[DEB_MSB:0]),
    .pen_absent (pen_absent),
    .pen_up_q   (pen_up)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_reset_clock_sel: assert property ($rose(reset_n) |-> dly_clk_q[BIT_CLK_SEL] && conv_clk_q[BIT_CLK_SEL])
    else $error("clock select bits not set after reset");
  a_delay_src_only: assert property (delay_clk_en == $past(dly_clk_q[BIT_CLK_SEL] ? dly_div_tick : osc_tick))
    else $error("delay enable not from its own source");
  a_conv_src_only: assert property (conv_clk_en == $past(conv_clk_q[BIT_CLK_SEL] ? conv_div_tick : osc_tick))
    else $error("converter enable not from its own source");
  a_no_gap_start: assert property (gap_q == TSA_IDLE && set_done && !gap_apply |=> scan_start)
    else $error("start not given when no gap applies");
  a_gap_blocks_start: assert property (gap_q == TSA_IDLE && set_done && gap_apply |=> delay_active && !scan_start)
    else $error("gap delay not started at end of set");
  a_gap_release: assert property (gap_q == TSA_FIRE |=> scan_start && !delay_active)
    else $error("start not issued after the gap");
  a_hold_stops: assert property (iface_q[BIT_HOLD_MODE] && iface_q[BIT_HOLD] |=> !buf_update_en)
    else $error("buffer still updating under host hold");
  a_detect_mode: assert property (!iface_q[BIT_HOLD_MODE] |=> buf_update_en == !$past(buf_host_reading))
    else $error("internal detection not followed");
  a_iface_write: assert property (reg_wr && reg_addr == OFF_IFACE_DEB |=> iface_i2c == $past(reg_wdata[7]))
    else $error("interface bit not written");
  a_aux_omit: assert property (reg_wr && reg_addr == OFF_AUX_SEL |=> auto_first_auxiliary_input_en == $past(reg_wdata[7]))
    else $error("auto aux enable not written");
endmodule

// File: testbench/tsa_panel_model.sv
// Far-side model: oscillator pulses, panel contact sense and host buffer reads.
// Assumes the bench commands contact and reads at the falling edge; they pass straight through.
`timescale 1ns/1ps
module tsa_panel_model #(
  parameter int OSC_DIV = 5
) (
  input  wire logic ref_clk,          // master clock
  input  wire logic pen_lift,         // bench command: finger leaves the panel
  input  wire logic host_read,        // bench command: host reads the buffer
  output logic      osc_tick,         // internal oscillator period pulse
  output logic      pen_absent,       // raw contact sense, high when lifted
  output logic      buf_host_reading  // host buffer read in progress
);
  int osc_cnt = 0;
  initial begin
    osc_tick = 1'b0;
  end
  // Contact and read levels follow the commands at once, so no same-edge race with the bench.
  assign pen_absent       = pen_lift;
  assign buf_host_reading = host_read;
  // The oscillator runs free and unrelated to the divider phase, as a real one would.
  always @(negedge ref_clk) begin
    osc_cnt = (osc_cnt == OSC_DIV - 1) ? 0 : osc_cnt + 1;
    osc_tick <= (osc_cnt == 0);
  end
endmodule

// File: testbench/tb_top.sv
// Self-checking bench for the clock select, gap delay, buffer hold, pen-up and aux block.
// Assumes tsa_pkg and the design files are compiled first.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin fail_count++; $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
module tb_top;
  import tsa_pkg::*;
  logic ref_clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, set_done = 1'b0;
  logic host_ctrl_mode = 1'b0, set_is_xy = 1'b0, pen_lift = 1'b0, host_read = 1'b0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [15:0] delay_ticks = 16'h0003;
  logic osc_tick, pen_absent, buf_host_reading, conv_clk_en, delay_clk_en, delay_active;
  logic scan_start, buf_update_en, iface_i2c, pen_up, a1, a2, vb, te, ts, r1, r2, eb;
  int fail_count = 0, checks_done = 0;
  tsa_panel_model #(.OSC_DIV(5)) PANEL (.ref_clk(ref_clk), .pen_lift(pen_lift), .host_read(host_read),
    .osc_tick(osc_tick), .pen_absent(pen_absent), .buf_host_reading(buf_host_reading));
  tsa_top DUT (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .osc_tick(osc_tick), .host_ctrl_mode(host_ctrl_mode),
    .set_is_xy(set_is_xy), .set_done(set_done), .delay_ticks(delay_ticks), .pen_absent(pen_absent),
    .buf_host_reading(buf_host_reading), .conv_clk_en(conv_clk_en), .delay_clk_en(delay_clk_en),
    .delay_active(delay_active), .scan_start(scan_start), .buf_update_en(buf_update_en),
    .iface_i2c(iface_i2c), .pen_up(pen_up), .auto_first_auxiliary_input_en(a1), .auto_second_auxiliary_input_en(a2), .auto_vbat_en(vb),
    .auto_temp_en(te), .temp_method_sel(ts), .first_auxiliary_input_resist(r1), .second_auxiliary_input_resist(r2), .ext_bias(eb));
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  // ****************************************************************
  // Register access and shared helpers
  // ****************************************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a; reg_wdata = d; reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] ex);
    @(negedge ref_clk);
    reg_addr = a;
    @(negedge ref_clk);
    `CHK("reg_rdata", ex, reg_rdata)
  endtask
  task automatic give_verdict;
    $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    rd_chk(OFF_SCAN_TIMER, 8'h40);
    rd_chk(OFF_DELAY_CLK, 8'h81);
    rd_chk(OFF_CONV_CLK, 8'h81);
    rd_chk(OFF_IFACE_DEB, 8'h00);
    rd_chk(OFF_AUX_SEL, 8'h00);
    `CHK("buf_update_en", 1'b1, buf_update_en)
    `CHK("pen_up", 1'b0, pen_up)
    $display("test reset values done");
  endtask
  task automatic t_regs;
    logic [7:0] pats [2] = '{8'ha5, 8'h5a};
    foreach (pats[i]) begin
      wr(OFF_AUX_SEL, pats[i]);
      rd_chk(OFF_AUX_SEL, pats[i]);
      `CHK("aux_outputs", pats[i], {a1, a2, vb, te, ts, r1, r2, eb})
    end
    wr(OFF_IFACE_DEB, 8'h80);
    rd_chk(OFF_IFACE_DEB, 8'h80);
    `CHK("iface_i2c", 1'b1, iface_i2c)
    wr(OFF_IFACE_DEB, 8'h00);
    rd_chk(OFF_IFACE_DEB, 8'h00);
    `CHK("iface_i2c", 1'b0, iface_i2c)
    wr(8'h14, 8'hff);
    rd_chk(8'h14, 8'h00);
    $display("test register fields done");
  endtask
  task automatic t_div;
    logic [7:0] dsel [3] = '{8'h84, 8'h80, 8'h05};
    logic [7:0] csel [3] = '{8'h83, 8'h00, 8'h82};
    int ncyc [3] = '{84, 640, 640};
    int exd [3] = '{21, 5, 128};
    int exc [3] = '{28, 128, 320};
    int dn, cn;
    for (int k = 0; k < 3; k++) begin
      wr(OFF_DELAY_CLK, dsel[k]);
      wr(OFF_CONV_CLK, csel[k]);
      repeat (140) @(negedge ref_clk);
      dn = 0; cn = 0;
      repeat (ncyc[k]) begin
        @(negedge ref_clk);
        dn += int'(delay_clk_en === 1'b1);
        cn += int'(conv_clk_en === 1'b1);
      end
      `CHK("delay_clk_pulses", exd[k], dn)
      `CHK("conv_clk_pulses", exc[k], cn)
    end
    wr(OFF_DELAY_CLK, 8'h81);
    wr(OFF_CONV_CLK, 8'h85);
    $display("test clock dividers done");
  endtask
  task automatic t_gap(input logic en, input logic hc, input logic xy, input logic gap);
    int n;
    logic act;
    wr(OFF_SCAN_TIMER, en ? 8'hc0 : 8'h40);
    wr(OFF_DELAY_CLK, 8'h82);
    host_ctrl_mode = hc; set_is_xy = xy;
    repeat (4) @(negedge ref_clk);
    set_done = 1'b1;
    n = 0; act = 1'b0;
    do begin
      @(negedge ref_clk);
      set_done = gap && n == 2;
      n++;
      act |= delay_active;
    end while (scan_start !== 1'b1 && n < 40);
    set_done = 1'b0;
    `CHK("gap_seen", gap, act)
    if (gap) begin
      `CHK("gap_len_ok", 1'b1, n >= 5 && n <= 10)
      repeat (12) begin
        @(negedge ref_clk);
        `CHK("scan_start_extra", 1'b0, scan_start)
      end
    end else `CHK("start_latency", 1, n)
    $display("test gap en=%0b host=%0b xy=%0b done", en, hc, xy);
  endtask
  task automatic t_buf;
    wr(OFF_IFACE_DEB, 8'h60);
    @(negedge ref_clk);
    `CHK("buf_update_en", 1'b0, buf_update_en)
    host_read = 1'b0;
    wr(OFF_IFACE_DEB, 8'h40);
    @(negedge ref_clk);
    `CHK("buf_update_en", 1'b1, buf_update_en)
    wr(OFF_IFACE_DEB, 8'h20);
    @(negedge ref_clk);
    `CHK("buf_update_en", 1'b1, buf_update_en)
    host_read = 1'b1;
    repeat (3) @(negedge ref_clk);
    `CHK("buf_update_en", 1'b0, buf_update_en)
    host_read = 1'b0;
    repeat (3) @(negedge ref_clk);
    `CHK("buf_update_en", 1'b1, buf_update_en)
    $display("test buffer hold done");
  endtask
  task automatic t_pen(input logic [7:0] dsel, input logic [2:0] code, input int lo, input int hi);
    int n;
    wr(OFF_DELAY_CLK, dsel);
    wr(OFF_IFACE_DEB, {5'h00, code});
    repeat (4) @(negedge ref_clk);
    pen_lift = 1'b1;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (pen_up !== 1'b1 && n < hi + 4);
    `CHK("pen_up_delay_ok", 1'b1, n >= lo && n <= hi)
    pen_lift = 1'b0;
    repeat (3) @(negedge ref_clk);
    `CHK("pen_up_clear", 1'b0, pen_up)
    $display("test pen-up code=%0d done", code);
  endtask
  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    repeat (2) @(negedge ref_clk);
    reset_n = 1'b1;
    t_reset();
    t_regs();
    t_div();
    t_gap(1'b1, 1'b0, 1'b0, 1'b1);
    t_gap(1'b1, 1'b1, 1'b0, 1'b0);
    t_gap(1'b1, 1'b1, 1'b1, 1'b1);
    delay_ticks = 16'h0000;
    t_gap(1'b1, 1'b0, 1'b0, 1'b0);
    delay_ticks = 16'h0003;
    t_gap(1'b0, 1'b0, 1'b0, 1'b0);
    t_buf();
    t_pen(8'h81, 3'h0, 1, 3);
    t_pen(8'h81, 3'h1, 7, 12);
    t_pen(8'h81, 3'h3, 30, 37);
    t_pen(8'h05, 3'h1, 36, 48);
    give_verdict();
  end
  // The whole sequence needs about 2100 cycles; the limit leaves a wide margin.
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    give_verdict();
  end
endmodule
